// ---- rtl/bnau_pkg.sv ----
// ============================================================
// branch next address unit: shared constants and types
package bnau_pkg;

   // ============================================================
   // widths
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned JUMP_OFF_W = 24;
   localparam int unsigned COND_OFF_W = 14;
   localparam int unsigned OPT_W = 5;
   localparam int unsigned SEL_W = 5;
   localparam int unsigned GROUP_W = 3;
   localparam int unsigned MNEM_W = 5;

   // ============================================================
   // option bit positions, bit 0 is the least significant bit
   localparam int unsigned OPT_IGNORE_COND_POS = 4;
   localparam int unsigned OPT_COND_SENSE_POS = 3;
   localparam int unsigned OPT_NO_DEC_POS = 2;
   localparam int unsigned OPT_ZERO_SENSE_POS = 1;
   localparam int unsigned OPT_HINT_POS = 0;

   // ============================================================
   // option codes of the simplified forms
   localparam logic [OPT_W-1:0] OPT_DNZ_FALSE = 5'h00;
   localparam logic [OPT_W-1:0] OPT_DZ_FALSE = 5'h02;
   localparam logic [OPT_W-1:0] OPT_IF_FALSE = 5'h04;
   localparam logic [OPT_W-1:0] OPT_DNZ_TRUE = 5'h08;
   localparam logic [OPT_W-1:0] OPT_DZ_TRUE = 5'h0A;
   localparam logic [OPT_W-1:0] OPT_IF_TRUE = 5'h0C;
   localparam logic [OPT_W-1:0] OPT_DNZ = 5'h10;
   localparam logic [OPT_W-1:0] OPT_DZ = 5'h12;
   localparam logic [OPT_W-1:0] OPT_ALWAYS = 5'h14;

   // ============================================================
   // condition bit offsets inside a group
   localparam logic [1:0] CBIT_LESS = 2'h0;
   localparam logic [1:0] CBIT_GREATER = 2'h1;
   localparam logic [1:0] CBIT_EQUAL = 2'h2;
   localparam logic [1:0] CBIT_OVERFLOW = 2'h3;

   // ============================================================
   // address step and reset values
   localparam logic [ADDR_W-1:0] INSN_STEP = 32'h0000_0004;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] COUNT_RESET = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] LINK_RESET = 32'h0000_0000;

   // ============================================================
   // simplified branch forms
   typedef enum logic [MNEM_W-1:0] {
      BNAU_M_DNZ = 5'h00,
      BNAU_M_DZ = 5'h01,
      BNAU_M_DNZF = 5'h02,
      BNAU_M_DZF = 5'h03,
      BNAU_M_DNZT = 5'h04,
      BNAU_M_DZT = 5'h05,
      BNAU_M_EQ = 5'h06,
      BNAU_M_NE = 5'h07,
      BNAU_M_LT = 5'h08,
      BNAU_M_GE = 5'h09,
      BNAU_M_GT = 5'h0A,
      BNAU_M_LE = 5'h0B,
      BNAU_M_SO = 5'h0C,
      BNAU_M_NS = 5'h0D,
      BNAU_M_BT = 5'h0E,
      BNAU_M_BF = 5'h0F,
      BNAU_M_ALWAYS = 5'h10
   } bnau_mnem_e;

   // resolver states
   typedef enum logic [1:0] {
      BNAU_S_IDLE = 2'b01,
      BNAU_S_DONE = 2'b10
   } bnau_state_e;

   // one branch request
   typedef struct packed {
      logic is_cond;
      logic absolute_addr_flag;
      logic link_update_flag;
      logic [JUMP_OFF_W-1:0] jump_offset_field;
      logic [COND_OFF_W-1:0] cond_offset_field;
      logic [OPT_W-1:0] branch_options_field;
      logic [SEL_W-1:0] condition_flag_select;
      logic [ADDR_W-1:0] current_fetch_address;
   } bnau_req_s;

   // one resolved branch
   typedef struct packed {
      logic taken;
      logic predict_hint;
      logic [ADDR_W-1:0] next_fetch_address;
   } bnau_res_s;

endpackage : bnau_pkg

// ---- rtl/bnau_mnem_decode.sv ----
`timescale 1ns/1ps
// ============================================================
// simplified form to option and condition bit codes
module bnau_mnem_decode (
   // form in
   input wire bnau_pkg::bnau_mnem_e mnem,
   input wire logic group_given,
   input wire logic [bnau_pkg::GROUP_W-1:0] condition_group_index,
   input wire logic [bnau_pkg::SEL_W-1:0] cr_bit,
   // codes out
   output logic [bnau_pkg::OPT_W-1:0] branch_options_field,
   output logic [bnau_pkg::SEL_W-1:0] condition_flag_select
);

   logic [bnau_pkg::GROUP_W-1:0] group;

   function automatic logic [bnau_pkg::SEL_W-1:0] group_bit(
      input logic [bnau_pkg::GROUP_W-1:0] g,
      input logic [1:0] offs
   );
      group_bit = {g, offs};
   endfunction : group_bit

   assign group = group_given ? condition_group_index : '0;

   always_comb
   begin
      branch_options_field = bnau_pkg::OPT_ALWAYS;
      condition_flag_select = '0;
      case (mnem)
         bnau_pkg::BNAU_M_DNZ: branch_options_field = bnau_pkg::OPT_DNZ;
         bnau_pkg::BNAU_M_DZ: branch_options_field = bnau_pkg::OPT_DZ;
         bnau_pkg::BNAU_M_DZF:
         begin
            branch_options_field = bnau_pkg::OPT_DZ_FALSE;
            condition_flag_select = cr_bit;
         end
         bnau_pkg::BNAU_M_DZT:
         begin
            branch_options_field = bnau_pkg::OPT_DZ_TRUE;
            condition_flag_select = cr_bit;
         end
         bnau_pkg::BNAU_M_DNZF:
         begin
            branch_options_field = bnau_pkg::OPT_DNZ_FALSE;
            condition_flag_select = cr_bit;
         end
         bnau_pkg::BNAU_M_DNZT:
         begin
            branch_options_field = bnau_pkg::OPT_DNZ_TRUE;
            condition_flag_select = cr_bit;
         end
         bnau_pkg::BNAU_M_BT:
         begin
            branch_options_field = bnau_pkg::OPT_IF_TRUE;
            condition_flag_select = cr_bit;
         end
         bnau_pkg::BNAU_M_BF:
         begin
            branch_options_field = bnau_pkg::OPT_IF_FALSE;
            condition_flag_select = cr_bit;
         end
         bnau_pkg::BNAU_M_LT:
         begin
            branch_options_field = bnau_pkg::OPT_IF_TRUE;
            condition_flag_select = group_bit(group, bnau_pkg::CBIT_LESS);
         end
         bnau_pkg::BNAU_M_GE:
         begin
            branch_options_field = bnau_pkg::OPT_IF_FALSE;
            condition_flag_select = group_bit(group, bnau_pkg::CBIT_LESS);
         end
         bnau_pkg::BNAU_M_GT:
         begin
            branch_options_field = bnau_pkg::OPT_IF_TRUE;
            condition_flag_select = group_bit(group, bnau_pkg::CBIT_GREATER);
         end
         bnau_pkg::BNAU_M_LE:
         begin
            branch_options_field = bnau_pkg::OPT_IF_FALSE;
            condition_flag_select = group_bit(group, bnau_pkg::CBIT_GREATER);
         end
         bnau_pkg::BNAU_M_EQ:
         begin
            branch_options_field = bnau_pkg::OPT_IF_TRUE;
            condition_flag_select = group_bit(group, bnau_pkg::CBIT_EQUAL);
         end
         bnau_pkg::BNAU_M_NE:
         begin
            branch_options_field = bnau_pkg::OPT_IF_FALSE;
            condition_flag_select = group_bit(group, bnau_pkg::CBIT_EQUAL);
         end
         bnau_pkg::BNAU_M_SO:
         begin
            branch_options_field = bnau_pkg::OPT_IF_TRUE;
            condition_flag_select = group_bit(group, bnau_pkg::CBIT_OVERFLOW);
         end
         bnau_pkg::BNAU_M_NS:
         begin
            branch_options_field = bnau_pkg::OPT_IF_FALSE;
            condition_flag_select = group_bit(group, bnau_pkg::CBIT_OVERFLOW);
         end
         bnau_pkg::BNAU_M_ALWAYS: branch_options_field = bnau_pkg::OPT_ALWAYS;
         default:
         begin
            branch_options_field = bnau_pkg::OPT_ALWAYS;
            condition_flag_select = '0;
         end
      endcase
   end

endmodule : bnau_mnem_decode

// ---- rtl/bnau_top.sv ----
`timescale 1ns/1ps
module bnau_top #(
   parameter int unsigned ADDR_W = bnau_pkg::ADDR_W
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // branch request
   input wire logic req_valid,
   output logic req_ready,
   input wire bnau_pkg::bnau_req_s req,
   // condition register from the core
   input wire logic [ADDR_W-1:0] condition_reg,
   // counter and link loads from the core
   input wire logic count_load,
   input wire logic [ADDR_W-1:0] count_load_value,
   input wire logic link_load,
   input wire logic [ADDR_W-1:0] link_load_value,
   // simplified form decode
   input wire bnau_pkg::bnau_mnem_e mnem,
   input wire logic mnem_group_given,
   input wire logic [bnau_pkg::GROUP_W-1:0] mnem_group_index,
   input wire logic [bnau_pkg::SEL_W-1:0] mnem_cr_bit,
   output logic [bnau_pkg::OPT_W-1:0] mnem_options,
   output logic [bnau_pkg::SEL_W-1:0] mnem_select,
   // resolved branch
   output logic res_valid,
   output bnau_pkg::bnau_res_s res,
   // architected registers
   output logic [ADDR_W-1:0] loop_count_reg,
   output logic [ADDR_W-1:0] return_link_reg
);

   // ============================================================
   // reset release
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // ============================================================
   // helpers
   function automatic logic [ADDR_W-1:0] exts_jump(input logic [bnau_pkg::JUMP_OFF_W-1:0] f);
      exts_jump = {{(ADDR_W - bnau_pkg::JUMP_OFF_W - 2){f[bnau_pkg::JUMP_OFF_W-1]}}, f, 2'b00};
   endfunction : exts_jump

   function automatic logic [ADDR_W-1:0] exts_cond(input logic [bnau_pkg::COND_OFF_W-1:0] f);
      exts_cond = {{(ADDR_W - bnau_pkg::COND_OFF_W - 2){f[bnau_pkg::COND_OFF_W-1]}}, f, 2'b00};
   endfunction : exts_cond

   function automatic logic opt_bit(input logic [bnau_pkg::OPT_W-1:0] o, input int unsigned pos);
      opt_bit = o[pos];
   endfunction : opt_bit

   // ============================================================
   // simplified form decode
   bnau_mnem_decode u_mnem (
      .mnem(mnem),
      .group_given(mnem_group_given),
      .condition_group_index(mnem_group_index),
      .cr_bit(mnem_cr_bit),
      .branch_options_field(mnem_options),
      .condition_flag_select(mnem_select)
   );

   // ============================================================
   // branch evaluation
   bnau_pkg::bnau_state_e state_q;
   bnau_pkg::bnau_state_e state_d;
   logic [ADDR_W-1:0] count_q;
   logic [ADDR_W-1:0] count_d;
   logic [ADDR_W-1:0] link_q;
   logic [ADDR_W-1:0] link_d;
   bnau_pkg::bnau_res_s res_q;
   bnau_pkg::bnau_res_s res_d;
   logic [ADDR_W-1:0] base;
   logic [ADDR_W-1:0] disp;
   logic [ADDR_W-1:0] target;
   logic [ADDR_W-1:0] seq_addr;
   logic [ADDR_W-1:0] count_dec;
   logic decrement;
   logic cond_bit;
   logic ctr_ok;
   logic cond_ok;
   logic taken;
   logic fire;

   assign req_ready = 1'b1;
   assign fire = req_valid && rst_sync_q;

   assign base = req.absolute_addr_flag ? '0 : req.current_fetch_address;
   assign disp = req.is_cond ? exts_cond(req.cond_offset_field) : exts_jump(req.jump_offset_field);
   assign target = base + disp;
   assign seq_addr = req.current_fetch_address + bnau_pkg::INSN_STEP;

   // decrement on conditional branches when options bit 2 clear
   assign decrement = req.is_cond && !opt_bit(req.branch_options_field, bnau_pkg::OPT_NO_DEC_POS);
   assign count_dec = count_q - 1'b1;
   // condition bit 0 is the msb
   assign cond_bit = condition_reg[ADDR_W - 1 - int'(req.condition_flag_select)];

   assign ctr_ok = opt_bit(req.branch_options_field, bnau_pkg::OPT_NO_DEC_POS)
      || ((count_dec == '0) == opt_bit(req.branch_options_field, bnau_pkg::OPT_ZERO_SENSE_POS));
   assign cond_ok = opt_bit(req.branch_options_field, bnau_pkg::OPT_IGNORE_COND_POS)
      || (cond_bit == opt_bit(req.branch_options_field, bnau_pkg::OPT_COND_SENSE_POS));
   assign taken = !req.is_cond || (ctr_ok && cond_ok);

   always_comb
   begin
      state_d = state_q;
      count_d = count_q;
      link_d = link_q;
      res_d = res_q;
      case (state_q)
         bnau_pkg::BNAU_S_IDLE,
         bnau_pkg::BNAU_S_DONE:
         begin
            state_d = fire ? bnau_pkg::BNAU_S_DONE : bnau_pkg::BNAU_S_IDLE;
         end
         default:
         begin
            state_d = bnau_pkg::BNAU_S_IDLE;
         end
      endcase
      if (count_load)
      begin
         count_d = count_load_value;
      end
      if (link_load)
      begin
         link_d = link_load_value;
      end
      if (fire)
      begin
         if (decrement)
         begin
            count_d = count_dec;
         end
         if (req.link_update_flag)
         begin
            link_d = seq_addr;
         end
         res_d.taken = taken;
         res_d.predict_hint = opt_bit(req.branch_options_field, bnau_pkg::OPT_HINT_POS);
         // low two bits forced to zero
         res_d.next_fetch_address = {(taken ? target[ADDR_W-1:2] : seq_addr[ADDR_W-1:2]), 2'b00};
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         state_q <= bnau_pkg::BNAU_S_IDLE;
         count_q <= bnau_pkg::COUNT_RESET;
         link_q <= bnau_pkg::LINK_RESET;
         res_q <= '{taken: 1'b0, predict_hint: 1'b0, next_fetch_address: bnau_pkg::ADDR_RESET};
      end
      else
      begin
         state_q <= state_d;
         count_q <= count_d;
         link_q <= link_d;
         res_q <= res_d;
      end
   end

   // ============================================================
   // outputs
   assign res_valid = (state_q == bnau_pkg::BNAU_S_DONE);
   assign res = res_q;
   assign loop_count_reg = count_q;
   assign return_link_reg = link_q;

endmodule : bnau_top

// ---- tb/bnau_top_properties.sv ----
`timescale 1ns/1ps
// ==========
// port checks of the branch unit
module bnau_checker #(
   parameter int unsigned ADDR_W = 32
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // request side
   input wire logic req_valid,
   input wire bnau_pkg::bnau_req_s req,
   input wire logic count_load,
   input wire logic link_load,
   input wire bnau_pkg::bnau_mnem_e mnem,
   input wire logic [bnau_pkg::OPT_W-1:0] mnem_options,
   // result side
   input wire logic res_valid,
   input wire bnau_pkg::bnau_res_s res,
   input wire logic [ADDR_W-1:0] loop_count_reg,
   input wire logic [ADDR_W-1:0] return_link_reg
);
   logic [1:0] up_q;
   logic [1:0] up_d;
   // cycles since reset release, saturating
   always_comb
   begin
      up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
   end
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         up_q <= 2'h0;
      else
         up_q <= up_d;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_take;
      up_q == 2'h3 && req_valid;
   endsequence
   sequence s_cond_dec;
      s_take ##0 (req.is_cond && !req.branch_options_field[2]);
   endsequence
   a_res_follows: assert property (s_take |=> res_valid)
      else $error("no result after request");
   a_res_spurious: assert property (!req_valid |=> !res_valid)
      else $error("result without request");
   a_link_write: assert property (s_take ##0 req.link_update_flag |=>
      return_link_reg == $past(req.current_fetch_address) + 32'h4)
      else $error("link value wrong");
   a_link_keep: assert property (s_take ##0 (!req.link_update_flag && !link_load) |=>
      $stable(return_link_reg))
      else $error("link changed");
   a_count_dec: assert property (s_cond_dec |=> loop_count_reg == $past(loop_count_reg) - 32'h1)
      else $error("counter not decremented");
   a_count_keep: assert property (s_take ##0 ((!req.is_cond || req.branch_options_field[2])
      && !count_load) |=> $stable(loop_count_reg))
      else $error("counter changed");
   a_seq_addr: assert property (res_valid && !res.taken |->
      res.next_fetch_address == (($past(req.current_fetch_address) + 32'h4) & 32'hFFFF_FFFC))
      else $error("fall through address wrong");
   a_addr_align: assert property (res_valid |-> res.next_fetch_address[1:0] == 2'h0)
      else $error("next address unaligned");
   a_always_taken: assert property (s_take ##0 (!req.is_cond || req.branch_options_field == 5'h14)
      |=> res.taken)
      else $error("unconditional branch not taken");
   a_hint_copy: assert property (s_take |=> res.predict_hint == $past(req.branch_options_field[0]))
      else $error("hint wrong");
   a_decode_always: assert property (mnem == bnau_pkg::BNAU_M_ALWAYS |-> mnem_options == 5'h14)
      else $error("always form code wrong");
endmodule : bnau_checker

// ---- tb/test_branch_next_address_unit.sv ----
`timescale 1ns/1ps
// ==========
// branch unit bench
module test_branch_next_address_unit;
   logic core_clk;
   logic reset_n;
   logic req_valid;
   logic req_ready;
   bnau_pkg::bnau_req_s req;
   bnau_pkg::bnau_req_s r;
   logic [31:0] cond_reg_in;
   logic count_load;
   logic [31:0] count_load_value;
   logic link_load;
   logic [31:0] link_load_value;
   bnau_pkg::bnau_mnem_e mnem;
   logic mnem_group_given;
   logic [2:0] mnem_group_index;
   logic [4:0] mnem_cr_bit;
   logic [4:0] mnem_options;
   logic [4:0] mnem_select;
   logic res_valid;
   bnau_pkg::bnau_res_s res;
   logic [31:0] loop_count_reg;
   logic [31:0] return_link_reg;
   logic [31:0] exp_count;
   logic [31:0] exp_link;
   logic [97:0] e;
   logic [97:0] expq[$];
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   logic [4:0] codes [11] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h0A, 5'h0C, 5'h10, 5'h12, 5'h14, 5'h05, 5'h15};
   logic [4:0] dopt [17] = '{5'h10, 5'h12, 5'h00, 5'h02, 5'h08, 5'h0A, 5'h0C, 5'h04, 5'h0C, 5'h04, 5'h0C,
      5'h04, 5'h0C, 5'h04, 5'h0C, 5'h04, 5'h14};
   logic [4:0] dsel [17] = '{5'h00, 5'h00, 5'h09, 5'h09, 5'h09, 5'h09, 5'h0E, 5'h0E, 5'h0C, 5'h0C, 5'h0D,
      5'h0D, 5'h0F, 5'h0F, 5'h09, 5'h09, 5'h00};

   bnau_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .condition_reg(cond_reg_in), .count_load(count_load), .count_load_value(count_load_value),
      .link_load(link_load), .link_load_value(link_load_value), .mnem(mnem), .mnem_group_given(mnem_group_given),
      .mnem_group_index(mnem_group_index), .mnem_cr_bit(mnem_cr_bit), .mnem_options(mnem_options),
      .mnem_select(mnem_select), .res_valid(res_valid), .res(res), .loop_count_reg(loop_count_reg),
      .return_link_reg(return_link_reg));

   task automatic stop_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask : chk

   // ==========
   // access tasks, entered at a rising edge
   task automatic load(input logic [31:0] cval, input logic [31:0] lval);
      count_load <= 1'b1;
      count_load_value <= cval;
      link_load <= 1'b1;
      link_load_value <= lval;
      @(posedge core_clk);
      count_load <= 1'b0;
      link_load <= 1'b0;
      exp_count = cval;
      exp_link = lval;
      @(posedge core_clk);
   endtask : load

   task automatic br(input bnau_pkg::bnau_req_s q, input bit last);
      logic [31:0] disp;
      logic [31:0] nxt;
      logic tk;
      req <= q;
      req_valid <= 1'b1;
      @(posedge core_clk);
      if (q.is_cond && !q.branch_options_field[2])
         exp_count = exp_count - 32'h1;
      disp = q.is_cond ? {{16{q.cond_offset_field[13]}}, q.cond_offset_field, 2'b00}
         : {{6{q.jump_offset_field[23]}}, q.jump_offset_field, 2'b00};
      tk = !q.is_cond || ((q.branch_options_field[2] || ((exp_count == 32'h0) == q.branch_options_field[1]))
         && (q.branch_options_field[4] || cond_reg_in[31 - q.condition_flag_select] == q.branch_options_field[3]));
      nxt = tk ? (q.absolute_addr_flag ? 32'h0 : q.current_fetch_address) + disp : q.current_fetch_address + 32'h4;
      if (q.link_update_flag)
         exp_link = q.current_fetch_address + 32'h4;
      expq.push_back({tk, q.branch_options_field[0], nxt, exp_count, exp_link});
      if (last)
      begin
         req_valid <= 1'b0;
         @(posedge core_clk);
      end
   endtask : br

   // ==========
   // result monitor
   always @(posedge core_clk)
   begin
      #1;
      if (expq.size() > 0)
      begin
         e = expq.pop_front();
         chk(res_valid, 32'h1);
         chk(req_ready, 32'h1);
         chk(res.taken, e[97]);
         chk(res.predict_hint, e[96]);
         chk(res.next_fetch_address, e[95:64]);
         chk(loop_count_reg, e[63:32]);
         chk(return_link_reg, e[31:0]);
      end
   end

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         fail_count++;
         stop_test();
      end
   end

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   initial
   begin
      reset_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      cond_reg_in = 32'h0;
      count_load = 1'b0;
      count_load_value = 32'h0;
      link_load = 1'b0;
      link_load_value = 32'h0;
      mnem = bnau_pkg::BNAU_M_DNZ;
      mnem_group_given = 1'b0;
      mnem_group_index = 3'h0;
      mnem_cr_bit = 5'h00;
      exp_count = 32'h0;
      exp_link = 32'h0;
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk(loop_count_reg, 32'h0);
      // relative with link, then absolute at max offset
      r = '0;
      r.link_update_flag = 1'b1;
      r.jump_offset_field = 24'hFFFFFE;
      r.current_fetch_address = 32'h0000_1000;
      br(r, 1'b1);
      r.absolute_addr_flag = 1'b1;
      r.link_update_flag = 1'b0;
      r.jump_offset_field = 24'h7FFFFF;
      br(r, 1'b1);
      // eleven option codes, counter 0 and 1, condition 0 and 1
      r = '0;
      r.is_cond = 1'b1;
      r.cond_offset_field = 14'h2000;
      r.current_fetch_address = 32'h0001_0000;
      r.condition_flag_select = 5'h06;
      for (int i = 0; i < 11; i++)
      begin
         for (int j = 0; j < 4; j++)
         begin
            cond_reg_in <= j[0] ? 32'h0200_0000 : 32'hFDFF_FFFF;
            load({31'h0, j[1]}, 32'h0);
            r.branch_options_field = codes[i];
            r.absolute_addr_flag = j[0];
            r.link_update_flag = j[1];
            br(r, 1'b1);
         end
      end
      r.branch_options_field = 5'h0C;
      for (int s = 0; s < 32; s++)
      begin
         cond_reg_in <= s[0] ? ~(32'h8000_0000 >> s) : (32'h8000_0000 >> s);
         r.condition_flag_select = s[4:0];
         br(r, 1'b1);
      end
      // back to back decrements down to zero
      load(32'h3, 32'h0000_0040);
      r.branch_options_field = 5'h10;
      br(r, 1'b0);
      br(r, 1'b0);
      br(r, 1'b1);
      for (int i = 0; i < 17; i++)
      begin
         mnem <= bnau_pkg::bnau_mnem_e'(i[4:0]);
         mnem_group_given <= 1'b1;
         mnem_group_index <= 3'h3;
         mnem_cr_bit <= 5'h09;
         #1;
         chk(mnem_options, dopt[i]);
         chk(mnem_select, dsel[i]);
         @(posedge core_clk);
      end
      mnem <= bnau_pkg::BNAU_M_EQ;
      mnem_group_given <= 1'b0;
      mnem_group_index <= 3'h5;
      #1;
      chk(mnem_select, 32'h2);
      @(posedge core_clk);
      // second reset in mid-run, hit while results stand and registers hold nonzero values
      load(32'h5, 32'h0000_0044);
      br(r, 1'b0);
      @(posedge core_clk);
      reset_n <= 1'b0;
      req_valid <= 1'b0;
      #1;
      chk(loop_count_reg, 32'h0);
      chk(return_link_reg, 32'h0);
      chk(res.next_fetch_address, 32'h0);
      chk(res_valid, 32'h0);
      @(posedge core_clk);
      reset_n <= 1'b1;
      exp_count = 32'h0;
      exp_link = 32'h0;
      repeat (4) @(posedge core_clk);
      br(r, 1'b1);
      repeat (2) @(posedge core_clk);
      stop_test();
   end
endmodule : test_branch_next_address_unit

bind bnau_top bnau_checker #(.ADDR_W(ADDR_W)) i_chk (.core_clk(core_clk), .reset_n(reset_n),
   .req_valid(req_valid), .req(req), .count_load(count_load), .link_load(link_load), .mnem(mnem),
   .mnem_options(mnem_options), .res_valid(res_valid), .res(res), .loop_count_reg(loop_count_reg),
   .return_link_reg(return_link_reg));
